// File: core/nvh_consts.svh
// Timing counts and widths for the nonvolatile SRAM host controller
`ifndef NVH_CONSTS_SVH
`define NVH_CONSTS_SVH

`define NVH_ADDR_W 19
`define NVH_DATA_W 16
`define NVH_CLK_NS 10
// Setup, strobe, hold and store request times in ns
`define NVH_T_SETUP_NS 10
`define NVH_T_STROBE_NS 50
`define NVH_T_HOLD_NS 10
`define NVH_T_STORE_REQ_NS 30
`define NVH_SETUP_CYC ((`NVH_T_SETUP_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_STROBE_CYC ((`NVH_T_STROBE_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_HOLD_CYC ((`NVH_T_HOLD_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_STORE_REQ_CYC ((`NVH_T_STORE_REQ_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_CNT_W 4

`endif

// File: core/nvh_host.sv
// Host controller driving the async nonvolatile SRAM pins
//
// Behaviour
// - Address held stable from before write until strobe returns high.
// - Write data valid before and at the strobe's ending edge.
// - Output enable kept high for the whole write.
// - Host watches store/busy to see a running automatic store.
`include "nvh_consts.svh"
module nvh_host (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic req_valid_i,
   input wire nvh_pkg::nvh_req_t req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [15:0] rsp_rdata_o,
   output logic busy_o,
   output logic dirty_o,
   output nvh_pkg::nvh_pins_t pins_o,
   input wire logic [15:0] data_io_i,
   output logic [15:0] data_io_o,
   output logic data_io_oe_n_o,
   input wire logic store_busy_n_i,
   output logic store_busy_n_o,
   output logic store_busy_n_oe_n_o
);
   ////////////////////////////////////////////////////////////////////////
   nvh_pkg::nvh_state_t st_q, st_d;
   nvh_pkg::nvh_req_t cur_q, cur_d;
   nvh_pkg::nvh_pins_t pins_q, pins_d;
   logic [`NVH_CNT_W-1:0] cnt_q, cnt_d;
   logic [15:0] rdata_q, rdata_d;
   logic drive_q, drive_d;
   logic spull_q, spull_d;
   logic rsp_q, rsp_d;
   logic dirty_q, dirty_d;
   logic busy_seen;

   // Memory busy: pin low while we are not the one pulling
   assign busy_seen = !store_busy_n_i && !spull_q;

   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      pins_d = pins_q;
      cnt_d = cnt_q;
      rdata_d = rdata_q;
      drive_d = drive_q;
      spull_d = spull_q;
      rsp_d = 1'b0;
      dirty_d = dirty_q;
      case (st_q)
         nvh_pkg::NVH_IDLE: begin
            pins_d.chip_sel_n = 1'b1;
            pins_d.write_n = 1'b1;
            pins_d.out_en_n = 1'b1;
            drive_d = 1'b0;
            if (req_valid_i && store_busy_n_i) begin
               cur_d = req_i;
               if (req_i.store) begin
                  if (dirty_q) begin
                     spull_d = 1'b1;
                     cnt_d = `NVH_CNT_W'(`NVH_STORE_REQ_CYC);
                     st_d = nvh_pkg::NVH_SREQ;
                  end else begin
                     rsp_d = 1'b1;
                  end
               end else begin
                  pins_d.address_in = req_i.addr;
                  pins_d.upper_byte_sel_n = !req_i.byte_en[1];
                  pins_d.lower_byte_sel_n = !req_i.byte_en[0];
                  cnt_d = `NVH_CNT_W'(`NVH_SETUP_CYC);
                  st_d = nvh_pkg::NVH_SETUP;
               end
            end
         end
         nvh_pkg::NVH_SETUP: begin
            // no select while memory stores
            // A store that starts during setup stalls us here, counter parked at one
            if (cnt_q != `NVH_CNT_W'(1)) begin
               cnt_d = cnt_q - `NVH_CNT_W'(1);
            end else if (store_busy_n_i) begin
               pins_d.chip_sel_n = 1'b0;
               if (cur_q.wr) begin
                  pins_d.write_n = 1'b0;
                  pins_d.out_en_n = 1'b1;
                  drive_d = 1'b1;
               end else begin
                  pins_d.out_en_n = 1'b0;
               end
               cnt_d = `NVH_CNT_W'(`NVH_STROBE_CYC);
               st_d = nvh_pkg::NVH_STRB;
            end
         end
         nvh_pkg::NVH_STRB: begin
            cnt_d = cnt_q - `NVH_CNT_W'(1);
            if (cnt_q == `NVH_CNT_W'(1)) begin
               if (!cur_q.wr) begin
                  rdata_d = data_io_i;
               end else begin
                  dirty_d = 1'b1;
               end
               pins_d.chip_sel_n = 1'b1;
               pins_d.write_n = 1'b1;
               pins_d.out_en_n = 1'b1;
               cnt_d = `NVH_CNT_W'(`NVH_HOLD_CYC);
               st_d = nvh_pkg::NVH_HOLD;
            end
         end
         nvh_pkg::NVH_HOLD: begin
            cnt_d = cnt_q - `NVH_CNT_W'(1);
            if (cnt_q == `NVH_CNT_W'(1)) begin
               drive_d = 1'b0;
               rsp_d = 1'b1;
               st_d = nvh_pkg::NVH_IDLE;
            end
         end
         nvh_pkg::NVH_SREQ: begin
            cnt_d = cnt_q - `NVH_CNT_W'(1);
            if (cnt_q == `NVH_CNT_W'(1)) begin
               spull_d = 1'b0;
               st_d = nvh_pkg::NVH_SWAIT;
            end
         end
         nvh_pkg::NVH_SWAIT: begin
            // memory holds pin low while storing
            // Limitation: a store too short to see is taken as done
            if (store_busy_n_i) begin
               st_d = nvh_pkg::NVH_DONE;
            end
         end
         nvh_pkg::NVH_DONE: begin
            if (store_busy_n_i) begin
               dirty_d = 1'b0;
               rsp_d = 1'b1;
               st_d = nvh_pkg::NVH_IDLE;
            end
         end
         default: begin
            st_d = nvh_pkg::NVH_IDLE;
         end
      endcase
      if (st_q == nvh_pkg::NVH_IDLE && busy_seen) begin
         dirty_d = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= nvh_pkg::NVH_IDLE;
         cur_q <= '0;
         pins_q <= {5'h1F, 19'h00000};
         cnt_q <= '0;
         rdata_q <= 16'h0000;
         drive_q <= 1'b0;
         spull_q <= 1'b0;
         rsp_q <= 1'b0;
         dirty_q <= 1'b0;
      end else if (en_i) begin
         st_q <= st_d;
         cur_q <= cur_d;
         pins_q <= pins_d;
         cnt_q <= cnt_d;
         rdata_q <= rdata_d;
         drive_q <= drive_d;
         spull_q <= spull_d;
         rsp_q <= rsp_d;
         dirty_q <= dirty_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign req_ready_o = (st_q == nvh_pkg::NVH_IDLE) && store_busy_n_i;
   assign rsp_valid_o = rsp_q;
   assign rsp_rdata_o = rdata_q;
   assign busy_o = (st_q != nvh_pkg::NVH_IDLE) || !store_busy_n_i;
   assign dirty_o = dirty_q;
   assign pins_o = pins_q;
   assign data_io_o = cur_q.wdata;
   assign data_io_oe_n_o = !drive_q;
   // Open drain: only ever drive low
   assign store_busy_n_o = 1'b0;
   assign store_busy_n_oe_n_o = !spull_q;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   oe_write_high_a: assert property (!pins_o.write_n |-> pins_o.out_en_n)
      else $error("Output enable low during write");
   no_contend_a: assert property (!pins_o.out_en_n |-> data_io_oe_n_o)
      else $error("Host drives data during read");
   data_at_end_a: assert property ($rose(pins_o.write_n) |-> !data_io_oe_n_o)
      else $error("Write data not held at strobe end");
   addr_stable_a: assert property (!pins_o.chip_sel_n |=> $stable(pins_o.address_in))
      else $error("Address moved during access");
   no_access_busy_a: assert property
      ($fell(pins_o.chip_sel_n) |-> $past(store_busy_n_i))
      else $error("Access started while busy");
   store_pull_len_a: assert property
      ($rose(spull_q) && en_i |-> spull_q [*3])
      else $error("Store request pulse too short");
   clean_skip_a: assert property
      (st_q == nvh_pkg::NVH_IDLE && req_valid_i && req_i.store && !dirty_q
       && store_busy_n_i && en_i |=> !spull_q && rsp_valid_o)
      else $error("Store issued while clean");
   write_dirty_a: assert property
      ($rose(pins_o.write_n) && en_i |-> dirty_q)
      else $error("Write not marked dirty");
   done_wait_a: assert property
      (rsp_valid_o && $past(st_q) == nvh_pkg::NVH_DONE |-> $past(store_busy_n_i))
      else $error("Store done before pin high");

   rd_c: cover property ($rose(pins_o.out_en_n));
   wr_c: cover property ($rose(pins_o.write_n));
   st_c: cover property (st_q == nvh_pkg::NVH_DONE ##1 rsp_valid_o);
   busy_c: cover property (busy_seen && st_q == nvh_pkg::NVH_IDLE);
endmodule

// File: core/nvh_pkg.sv
// Types for the nonvolatile SRAM host controller
package nvh_pkg;
   typedef enum logic [6:0] {
      NVH_IDLE  = 7'h01,
      NVH_SETUP = 7'h02,
      NVH_STRB  = 7'h04,
      NVH_HOLD  = 7'h08,
      NVH_SREQ  = 7'h10,
      NVH_SWAIT = 7'h20,
      NVH_DONE  = 7'h40
   } nvh_state_t;

   // Host request
   typedef struct packed {
      logic wr;
      logic store;
      logic [18:0] addr;
      logic [15:0] wdata;
      logic [1:0] byte_en;
   } nvh_req_t;

   // Pins toward the memory
   typedef struct packed {
      logic chip_sel_n;
      logic write_n;
      logic out_en_n;
      logic upper_byte_sel_n;
      logic lower_byte_sel_n;
      logic [18:0] address_in;
   } nvh_pins_t;
endpackage

// File: verif/nvh_host_tb.sv
// Self-checking bench for the nonvolatile SRAM host controller
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module nvh_host_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic wr;
      logic [18:0] a;
      logic [15:0] d;
      logic [1:0] be;
   } nvh_row_t;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic en_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic pwr_fail = 1'b0;
   nvh_pkg::nvh_req_t req_i = '0;
   nvh_pkg::nvh_pins_t pins_o;
   logic req_ready_o, rsp_valid_o, busy_o, dirty_o, host_oe_n, sb_oe_n, sb_n;
   logic busy_seen, pull_seen, sb_drv;
   logic [15:0] rsp_rdata_o, dq, host_dq;
   int err_total = 0;
   int total_checks = 0;
   nvh_row_t rows [8] = '{'{1'b1, 19'h00010, 16'hA5C3, 2'h3},
      '{1'b1, 19'h3FFFF, 16'h1234, 2'h3}, '{1'b1, 19'h00010, 16'h7E00, 2'h2},
      '{1'b1, 19'h00010, 16'h0011, 2'h1}, '{1'b0, 19'h00010, 16'h7E11, 2'h3},
      '{1'b0, 19'h3FFFF, 16'h1234, 2'h3}, '{1'b1, 19'h00000, 16'hBEEF, 2'h3},
      '{1'b0, 19'h00000, 16'hBEEF, 2'h3}};

   nvh_host dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .en_i(en_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o), .dirty_o(dirty_o), .pins_o(pins_o),
      .data_io_i(dq), .data_io_o(host_dq), .data_io_oe_n_o(host_oe_n),
      .store_busy_n_i(sb_n), .store_busy_n_o(sb_drv), .store_busy_n_oe_n_o(sb_oe_n));
   nvh_mem_model mem_u (.pwr_fail_i(pwr_fail), .pins_i(pins_o), .host_dq_i(host_dq),
      .host_oe_n_i(host_oe_n), .host_sb_oe_n_i(sb_oe_n), .dq_o(dq), .store_busy_n_o(sb_n));

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   //////////////////////////////////////////////////
   always @(negedge mclk_i) begin
      if (!sb_oe_n) pull_seen = 1'b1;
      if (!sb_oe_n) `CHK(sb_drv, 1'b0)
      if (!pins_o.write_n) `CHK(pins_o.out_en_n, 1'b1)
      if (!rst_i && !sb_n && sb_oe_n) begin
         busy_seen = 1'b1;
         `CHK(pins_o.chip_sel_n, 1'b1)
         `CHK(busy_o, 1'b1)
      end
   end

   task automatic close_out();
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic op(input logic w, input logic s, input logic [18:0] a,
         input logic [15:0] d, input logic [1:0] be, input int stall);
      int n;
      req_i = '{wr: w, store: s, addr: a, wdata: d, byte_en: be};
      req_valid_i = 1'b1;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 300) begin @(posedge mclk_i); #1; n++; end
      if (n == 300) begin err_total++; close_out(); end
      @(posedge mclk_i);
      #1 req_valid_i = 1'b0;
      en_i = 1'b0;
      repeat (stall) @(posedge mclk_i);
      #1 en_i = 1'b1;
      n = 0;
      while (rsp_valid_o !== 1'b1 && n < 300) begin @(posedge mclk_i); #1; n++; end
      if (n == 300) begin err_total++; close_out(); end
   endtask

   task automatic power_drop();
      busy_seen = 1'b0;
      pwr_fail = 1'b1;
      @(posedge mclk_i);
      #1 pwr_fail = 1'b0;
      repeat (40) @(posedge mclk_i);
   endtask

   initial begin
      busy_seen = 1'b0;
      pull_seen = 1'b0;
      repeat (4) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      foreach (rows[i]) begin
         op(rows[i].wr, 1'b0, rows[i].a, rows[i].d, rows[i].be, 0);
         if (!rows[i].wr) `CHK(rsp_rdata_o, rows[i].d)
      end
      `CHK(dirty_o, 1'b1)
      op(1'b0, 1'b1, 19'h0, 16'h0, 2'h0, 0);
      `CHK({busy_seen, dirty_o, sb_n}, 3'h5)
      busy_seen = 1'b0;
      pull_seen = 1'b0;
      op(1'b0, 1'b1, 19'h0, 16'h0, 2'h0, 0);
      `CHK(pull_seen | busy_seen, 1'b0)
      op(1'b1, 1'b0, 19'h00020, 16'h5A5A, 2'h3, 5);
      power_drop();
      `CHK({busy_seen, dirty_o}, 2'h2)
      power_drop();
      `CHK(busy_seen, 1'b0)
      op(1'b0, 1'b0, 19'h00020, 16'h0, 2'h3, 5);
      `CHK(rsp_rdata_o, 16'h5A5A)
      op(1'b1, 1'b0, 19'h00030, 16'hC0DE, 2'h3, 0);
      #1 rst_i = 1'b1;
      #1 `CHK({pins_o.chip_sel_n, pins_o.out_en_n, host_oe_n, sb_oe_n, dirty_o}, 5'h1E)
      repeat (4) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      op(1'b0, 1'b0, 19'h00030, 16'h0, 2'h3, 0);
      `CHK(rsp_rdata_o, 16'hC0DE)
      close_out();
   end
endmodule

// File: verif/nvh_mem_model.sv
// Behavioural nonvolatile SRAM on the far side of the host controller
module nvh_mem_model #(
   parameter int STORE_NS = 303
) (
   input wire logic pwr_fail_i,
   input wire nvh_pkg::nvh_pins_t pins_i,
   input wire logic [15:0] host_dq_i,
   input wire logic host_oe_n_i,
   input wire logic host_sb_oe_n_i,
   output logic [15:0] dq_o,
   output logic store_busy_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [0:262143];
   logic [17:0] wr_addr;
   logic [15:0] last = 16'h0000;
   logic [15:0] rd_w;
   logic [1:0] lanes;
   logic dirty = 1'b0;
   logic busy = 1'b0;
   logic wr_on = 1'b0;
   logic rd_en;
   //////////////////////////////////////////////////
   // pull-up, low while storing
   assign store_busy_n_o = host_sb_oe_n_i & ~busy;
   // drive in a plain read, drop as soon as a control ends it
   assign rd_en = !pins_i.chip_sel_n && !pins_i.out_en_n && pins_i.write_n && store_busy_n_o;
   assign rd_w = mem[pins_i.address_in[17:0]];
   // a floating lane shows the inverse of its last level
   assign dq_o = !host_oe_n_i ? host_dq_i :
      {(rd_en && !pins_i.upper_byte_sel_n) ? rd_w[15:8] : ~last[15:8],
       (rd_en && !pins_i.lower_byte_sel_n) ? rd_w[7:0] : ~last[7:0]};
   always @(host_dq_i, host_oe_n_i, rd_w, rd_en) begin
      if (!host_oe_n_i) last = host_dq_i;
      else if (rd_en) last = rd_w;
   end
   always @(negedge pins_i.chip_sel_n) wr_addr = pins_i.address_in[17:0];
   always @(negedge pins_i.write_n or negedge pins_i.chip_sel_n) begin
      wr_on = !pins_i.chip_sel_n && !pins_i.write_n && store_busy_n_o;
      lanes = {pins_i.upper_byte_sel_n, pins_i.lower_byte_sel_n};
   end
   // data taken at the ending edge
   always @(posedge pins_i.write_n or posedge pins_i.chip_sel_n) begin
      if (wr_on) begin
         if (!lanes[1]) mem[wr_addr][15:8] = host_dq_i[15:8];
         if (!lanes[0]) mem[wr_addr][7:0] = host_dq_i[7:0];
         dirty = 1'b1;
      end
      wr_on = 1'b0;
   end
   // a software store would skip the dirty test; the host never issues one
   always @(negedge host_sb_oe_n_i or posedge pwr_fail_i) begin
      if (dirty && !busy) begin
         busy = 1'b1;
         #(STORE_NS);
         busy = 1'b0;
         dirty = 1'b0;
      end
   end
endmodule
